// ### hub_config_load_port.sv
/* Configuration load port: EEPROM boot master and block-only serial
   management slave sharing one clock/data pin pair.
   Assumes pins are open drain with pull-ups resolved outside, and
   that the hardware reset pin and straps are asynchronous. */
// Contract
// - EEPROM bus runs standard mode 100 kbit/s, 7-bit addressing only.
// - As EEPROM master, device drives clock, direction, START and STOP.
// - EEPROM read is dummy address write, repeated start, then reads.
// - EEPROM slave address is fixed 1010000, never 10-bit.
// - While hardware reset is low, all interface pins float.
// - Management mode selected by straps disables EEPROM loading.
// - Management mode waits forever for load; attach only after it.
// - Slave only; only block write and block read accepted.
// - 7-bit address, 8-bit command, 8-bit data, MSB first.
// - Block write is address+write, command, count, then data.
// - Count must be 1 to 32; zero or more than 32 is refused.
// - Block read is command write, repeated start read, count, data.
// - Registers change only after a complete valid block write.
// - Wrong address or bad protocol gets no ack, slave goes idle.
// - General call address zero is never acknowledged.
// - Clock low over 25 ms aborts; ready for START within 35 ms.
// - Device never holds management clock low; tolerates stretching.
// - START followed by STOP returns slave to idle.
// - Undefined register reads give 00h; writes silently ignored.
// - Hardware reset drops ports, ends transfers, restores defaults.
// - Operational 500 us after reset; then EEPROM load starts.
// - Attach bit ends load, attaches, write-protects 00h to FEh.
// - Soft-reset bit restores interface and registers to defaults.
`timescale 1ns/1ns
module hub_config_load_port #(
  parameter int         TOUT_CYC = hub_cfg_pkg::TOUT_CYC,
  parameter int         OPER_CYC = hub_cfg_pkg::OPER_CYC,
  parameter logic [7:0] REG_LAST = 8'h3F,
  parameter logic [7:0] EE_LAST  = 8'hFE,
  parameter logic [5:0] RD_LEN   = 6'h20
) (
  input  wire logic                 mclk_in,
  input  wire logic                 srst_in,
  input  wire logic                 hw_reset_n_in,
  input  wire logic                 config_source_select_hi_in,
  input  wire logic                 config_source_select_lo_in,
  input  wire logic [6:0]           slave_addr_in,
  input  wire logic                 mgmt_serial_clock_line_in,
  input  wire logic                 mgmt_serial_data_line_in,
  input  wire logic [7:0]           cfg_rd_addr_in,
  output hub_cfg_pkg::od_pin_t      mgmt_serial_clock_line_out,
  output hub_cfg_pkg::od_pin_t      mgmt_serial_data_line_out,
  output logic                      usb_attach_out,
  output logic [1:0]                port_power_enable_out,
  output logic                      eeprom_error_out,
  output logic                      smbus_mode_out,
  output logic                      serial_port_sleep_bit_out,
  output logic [7:0]                cfg_rd_data_out
);
  logic [2:0]            scl_sy_q;
  logic [2:0]            sda_sy_q;
  logic [1:0]            rst_sy_q;
  logic [3:0]            sel_sy_q;
  logic                  hw_ok;
  logic                  rst_all;
  logic                  soft_q;
  logic                  scl_s;
  logic                  scl_p;
  logic                  sda_s;
  logic                  sda_p;
  logic [31:0]           op_cnt_q;
  logic                  op_q;
  logic                  smb_q;
  logic [7:0]            q_cnt_q;
  logic                  qtick;
  hub_cfg_pkg::m_state_t m_st_q;
  logic [1:0]            m_ph_q;
  logic [3:0]            m_bit_q;
  logic [7:0]            m_sh_q;
  logic [1:0]            m_step_q;
  logic [7:0]            m_idx_q;
  logic                  m_scl_q;
  logic                  m_sda_q;
  logic                  m_nak_q;
  logic                  m_done_q;
  logic                  ee_err_q;
  logic                  m_we;
  hub_cfg_pkg::s_state_t s_st_q;
  logic [3:0]            s_bit_q;
  logic [7:0]            s_sh_q;
  logic [7:0]            s_tx_q;
  logic [7:0]            s_cmd_q;
  logic [5:0]            s_cnt_q;
  logic [5:0]            s_n_q;
  logic                  s_oe_q;
  logic                  s_rd_q;
  logic                  s_first_q;
  logic                  s_have_q;
  logic                  s_mack_q;
  logic                  smb_act;
  logic                  s_start;
  logic                  s_stop;
  logic                  s_rise;
  logic                  s_fall;
  logic                  s_tout;
  logic                  addr_ok;
  logic [31:0]           tout_cnt_q;
  logic [7:0]            buf_q [32];
  logic                  c_busy_q;
  logic [5:0]            c_idx_q;
  logic [5:0]            c_len_q;
  logic [7:0]            c_base_q;
  logic [7:0]            regs_q [256];
  logic [7:0]            wa;
  logic [7:0]            wd;
  logic                  reg_we;
  logic                  stat_wr;
  logic                  attach_q;
  logic                  sleep_q;
  logic [7:0]            stat_v;
  logic [7:0]            rd_addr;
  logic [7:0]            rd_next;
  logic [7:0]            cfg_rd_q;

  function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                         input logic [7:0] r,
                                         input logic [7:0] st);
    if (a == hub_cfg_pkg::STAT_REG)
      return st;
    else if (a <= REG_LAST)
      return r;
    else
      return hub_cfg_pkg::UNDEF_RD;
  endfunction

  // First stages feed only the second stages
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      scl_sy_q <= 3'h7;
      sda_sy_q <= 3'h7;
      rst_sy_q <= 2'h0;
      sel_sy_q <= 4'h0;
    end
    else
    begin
      scl_sy_q <= {scl_sy_q[1:0], mgmt_serial_clock_line_in};
      sda_sy_q <= {sda_sy_q[1:0], mgmt_serial_data_line_in};
      rst_sy_q <= {rst_sy_q[0], hw_reset_n_in};
      sel_sy_q <= {sel_sy_q[1:0], config_source_select_hi_in,
                   config_source_select_lo_in};
    end
  end

  assign hw_ok   = rst_sy_q[1];
  assign rst_all = srst_in || !hw_ok || soft_q;
  assign scl_s   = scl_sy_q[1];
  assign scl_p   = scl_sy_q[2];
  assign sda_s   = sda_sy_q[1];
  assign sda_p   = sda_sy_q[2];

  // Straps caught once, when the operational delay ends
  always_ff @(posedge mclk_in)
  begin
    if (rst_all)
    begin
      op_cnt_q <= 32'h0;
      op_q     <= 1'b0;
      smb_q    <= 1'b0;
    end
    else if (!op_q)
    begin
      if (op_cnt_q == 32'(OPER_CYC - 1))
      begin
        op_q  <= 1'b1;
        smb_q <= (sel_sy_q[3:2] == hub_cfg_pkg::SEL_SMBUS);
      end
      else
        op_cnt_q <= op_cnt_q + 32'h1;
    end
  end

  assign qtick = (q_cnt_q == 8'(hub_cfg_pkg::QTR_CYC - 1));

  always_ff @(posedge mclk_in)
  begin
    if (rst_all || qtick)
      q_cnt_q <= 8'h0;
    else
      q_cnt_q <= q_cnt_q + 8'h1;
  end

  assign m_we = qtick && (m_st_q == hub_cfg_pkg::M_RX) &&
                (m_ph_q == 2'h3) && (m_bit_q == 4'h8);

  // Quarter-bit phases: 0 set data, 1 release clock, 2 sample, 3 low
  always_ff @(posedge mclk_in)
  begin
    if (rst_all)
    begin
      m_st_q   <= hub_cfg_pkg::M_IDLE;
      m_ph_q   <= 2'h0;
      m_bit_q  <= 4'h0;
      m_sh_q   <= 8'h00;
      m_step_q <= 2'h0;
      m_idx_q  <= 8'h00;
      m_scl_q  <= 1'b0;
      m_sda_q  <= 1'b0;
      m_nak_q  <= 1'b0;
      m_done_q <= 1'b0;
      ee_err_q <= 1'b0;
    end
    else if (qtick)
    begin
      m_ph_q <= m_ph_q + 2'h1;
      case (m_st_q)
        hub_cfg_pkg::M_IDLE:
        begin
          m_ph_q <= 2'h0;
          if (op_q && !smb_q)
            m_st_q <= hub_cfg_pkg::M_START;
        end
        hub_cfg_pkg::M_START:
          case (m_ph_q)
            2'h0: m_sda_q <= 1'b0;
            2'h1: m_scl_q <= 1'b0;
            2'h2: m_sda_q <= 1'b1;
            default:
            begin
              m_scl_q <= 1'b1;
              m_bit_q <= 4'h0;
              m_st_q  <= hub_cfg_pkg::M_TX;
              m_sh_q  <= {hub_cfg_pkg::EE_ADDR, (m_step_q != 2'h0)};
            end
          endcase
        hub_cfg_pkg::M_TX,
        hub_cfg_pkg::M_RX:
          case (m_ph_q)
            2'h0:
              if (m_st_q == hub_cfg_pkg::M_TX)
                m_sda_q <= (m_bit_q != 4'h8) && !m_sh_q[7];
              else
                m_sda_q <= (m_bit_q == 4'h8) && (m_idx_q != EE_LAST);
            2'h1: m_scl_q <= 1'b0;
            2'h2:
              if (!scl_s)
                m_ph_q <= m_ph_q; // Slave stretching the clock
              else if (m_bit_q == 4'h8)
                m_nak_q <= sda_s;
              else if (m_st_q == hub_cfg_pkg::M_RX)
                m_sh_q <= {m_sh_q[6:0], sda_s};
            default:
            begin
              m_scl_q <= 1'b1;
              if (m_bit_q != 4'h8)
              begin
                m_bit_q <= m_bit_q + 4'h1;
                if (m_st_q == hub_cfg_pkg::M_TX)
                  m_sh_q <= {m_sh_q[6:0], 1'b0};
              end
              else
              begin
                m_bit_q <= 4'h0;
                if (m_st_q == hub_cfg_pkg::M_RX)
                begin
                  if (m_idx_q == EE_LAST)
                    m_st_q <= hub_cfg_pkg::M_STOP;
                  m_idx_q <= m_idx_q + 8'h1;
                end
                else if (m_nak_q)
                begin
                  ee_err_q <= 1'b1;
                  m_st_q   <= hub_cfg_pkg::M_STOP;
                end
                else
                begin
                  m_step_q <= m_step_q + 2'h1;
                  if (m_step_q == 2'h0)
                    m_sh_q <= hub_cfg_pkg::EE_WADDR;
                  else if (m_step_q == 2'h1)
                    m_st_q <= hub_cfg_pkg::M_START;
                  else
                    m_st_q <= hub_cfg_pkg::M_RX;
                end
              end
            end
          endcase
        hub_cfg_pkg::M_STOP:
          case (m_ph_q)
            2'h0: m_sda_q <= 1'b1;
            2'h1: m_scl_q <= 1'b0;
            2'h2: m_sda_q <= 1'b0;
            default:
            begin
              m_st_q   <= hub_cfg_pkg::M_DONE;
              m_done_q <= 1'b1;
            end
          endcase
        default: m_ph_q <= 2'h0;
      endcase
    end
  end

  assign smb_act = op_q && smb_q && !sleep_q;
  assign s_start = smb_act && scl_s && scl_p && sda_p && !sda_s;
  assign s_stop  = smb_act && scl_s && scl_p && !sda_p && sda_s;
  assign s_rise  = smb_act && scl_s && !scl_p;
  assign s_fall  = smb_act && !scl_s && scl_p;
  assign s_tout  = (tout_cnt_q == 32'(TOUT_CYC - 1));
  assign addr_ok = (s_sh_q[7:1] == slave_addr_in) && !c_busy_q &&
                   (s_sh_q[7:1] != hub_cfg_pkg::GEN_CALL);
  assign rd_addr = s_cmd_q + {2'b00, s_n_q};
  assign rd_next = rd_byte(rd_addr, regs_q[rd_addr], stat_v);

  always_ff @(posedge mclk_in)
  begin
    // Only a continuously low clock counts toward the abort
    if (rst_all || scl_s || (s_st_q == hub_cfg_pkg::S_IDLE))
      tout_cnt_q <= 32'h0;
    else if (!s_tout)
      tout_cnt_q <= tout_cnt_q + 32'h1;
  end

  // Stays on the clock-low side: the clock line is only ever sampled
  always_ff @(posedge mclk_in)
  begin
    if (rst_all)
    begin
      s_st_q    <= hub_cfg_pkg::S_IDLE;
      s_bit_q   <= 4'h0;
      s_sh_q    <= 8'h00;
      s_tx_q    <= 8'h00;
      s_cmd_q   <= 8'h00;
      s_cnt_q   <= 6'h00;
      s_n_q     <= 6'h00;
      s_oe_q    <= 1'b0;
      s_rd_q    <= 1'b0;
      s_first_q <= 1'b0;
      s_have_q  <= 1'b0;
      s_mack_q  <= 1'b0;
    end
    else if (s_stop || s_tout)
    begin
      s_st_q <= hub_cfg_pkg::S_IDLE;
      s_oe_q <= 1'b0;
      s_rd_q <= 1'b0;
    end
    else if (s_start)
    begin
      s_have_q <= (s_st_q == hub_cfg_pkg::S_CNT);
      s_st_q   <= hub_cfg_pkg::S_ADDR;
      // START's own clock fall then closes like an ack slot, not a bit
      s_bit_q  <= 4'h8;
      s_oe_q   <= 1'b0;
      s_rd_q   <= 1'b0;
    end
    else if (s_rise)
    begin
      if (s_bit_q != 4'h8)
        s_sh_q <= {s_sh_q[6:0], sda_s};
      else
        s_mack_q <= !sda_s;
    end
    else if (s_fall && (s_st_q != hub_cfg_pkg::S_IDLE) &&
             (s_st_q != hub_cfg_pkg::S_IGNORE))
    begin
      if (s_bit_q < 4'h7)
      begin
        s_bit_q <= s_bit_q + 4'h1;
        if (s_rd_q)
        begin
          s_oe_q <= !s_tx_q[6];
          s_tx_q <= {s_tx_q[6:0], 1'b0};
        end
      end
      else if (s_bit_q == 4'h7)
      begin
        s_bit_q <= 4'h8;
        s_oe_q  <= 1'b0;
        s_st_q  <= hub_cfg_pkg::S_IGNORE;
        if (!s_rd_q)
          case (s_st_q)
            hub_cfg_pkg::S_ADDR:
              if (addr_ok && (!s_sh_q[0] || s_have_q))
              begin
                s_oe_q    <= 1'b1;
                s_st_q    <= s_sh_q[0] ? hub_cfg_pkg::S_RDATA :
                                         hub_cfg_pkg::S_CMD;
                s_first_q <= 1'b1;
                s_n_q     <= 6'h00;
                s_tx_q    <= {2'b00, RD_LEN};
              end
            hub_cfg_pkg::S_CMD:
            begin
              s_oe_q  <= 1'b1;
              s_cmd_q <= s_sh_q;
              s_st_q  <= hub_cfg_pkg::S_CNT;
            end
            hub_cfg_pkg::S_CNT:
              if ((s_sh_q != 8'h00) &&
                  (s_sh_q <= {2'b00, hub_cfg_pkg::BLK_MAX}))
              begin
                s_oe_q  <= 1'b1;
                s_cnt_q <= s_sh_q[5:0];
                s_n_q   <= 6'h00;
                s_st_q  <= hub_cfg_pkg::S_WDATA;
              end
            hub_cfg_pkg::S_WDATA:
              if (s_n_q < s_cnt_q)
              begin
                s_oe_q          <= 1'b1;
                buf_q[s_n_q[4:0]] <= s_sh_q;
                s_n_q           <= s_n_q + 6'h01;
                s_st_q          <= hub_cfg_pkg::S_WDATA;
              end
            default: s_oe_q <= 1'b0;
          endcase
        else if (s_st_q == hub_cfg_pkg::S_RDATA)
          s_st_q <= hub_cfg_pkg::S_RDATA;
      end
      else
      begin
        s_bit_q <= 4'h0;
        s_oe_q  <= 1'b0;
        if (s_st_q == hub_cfg_pkg::S_RDATA)
        begin
          if (s_first_q)
          begin
            s_first_q <= 1'b0;
            s_rd_q    <= 1'b1;
            s_oe_q    <= !s_tx_q[7];
          end
          else if (s_mack_q && (s_n_q < RD_LEN))
          begin
            s_tx_q <= rd_next;
            s_oe_q <= !rd_next[7];
            s_n_q  <= s_n_q + 6'h01;
          end
          else
          begin
            s_rd_q <= 1'b0;
            s_st_q <= hub_cfg_pkg::S_IGNORE;
          end
        end
      end
    end
  end

  // Commit only after STOP closes a write whose byte count matched
  always_ff @(posedge mclk_in)
  begin
    if (rst_all)
    begin
      c_busy_q <= 1'b0;
      c_idx_q  <= 6'h00;
      c_len_q  <= 6'h00;
      c_base_q <= 8'h00;
    end
    else if (c_busy_q)
    begin
      c_idx_q <= c_idx_q + 6'h01;
      if (c_idx_q == c_len_q - 6'h01)
        c_busy_q <= 1'b0;
    end
    else if (s_stop && (s_st_q == hub_cfg_pkg::S_WDATA) &&
             (s_n_q == s_cnt_q))
    begin
      c_busy_q <= 1'b1;
      c_idx_q  <= 6'h00;
      c_len_q  <= s_cnt_q;
      c_base_q <= s_cmd_q;
    end
  end

  assign wa      = m_we ? m_idx_q : c_base_q + {2'b00, c_idx_q};
  assign wd      = m_we ? m_sh_q : buf_q[c_idx_q[4:0]];
  assign stat_wr = c_busy_q && (wa == hub_cfg_pkg::STAT_REG);
  assign reg_we  = m_we || (c_busy_q && !attach_q && (wa <= REG_LAST) &&
                   (wa != hub_cfg_pkg::STAT_REG));

  always_ff @(posedge mclk_in)
  begin
    if (rst_all)
    begin
      for (int i = 0; i < 256; i++)
        regs_q[i] <= hub_cfg_pkg::REG_RST;
    end
    else if (reg_we)
      regs_q[wa] <= wd;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_all)
    begin
      attach_q <= 1'b0;
      sleep_q  <= 1'b0;
    end
    else
    begin
      if (m_done_q || (stat_wr && wd[hub_cfg_pkg::ATT_BIT]))
        attach_q <= 1'b1;
      if (stat_wr && wd[hub_cfg_pkg::SLEEP_BIT])
        sleep_q <= 1'b1;
    end
  end

  // Soft reset is a one-cycle pulse that feeds the common reset
  always_ff @(posedge mclk_in)
  begin
    if (srst_in || !hw_ok)
      soft_q <= 1'b0;
    else
      soft_q <= stat_wr && wd[hub_cfg_pkg::SRST_BIT];
  end

  always_comb
  begin
    stat_v                         = 8'h00;
    stat_v[hub_cfg_pkg::ATT_BIT]   = attach_q;
    stat_v[hub_cfg_pkg::SLEEP_BIT] = sleep_q;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_all)
      cfg_rd_q <= 8'h00;
    else
      cfg_rd_q <= rd_byte(cfg_rd_addr_in, regs_q[cfg_rd_addr_in], stat_v);
  end

  assign mgmt_serial_clock_line_out.out = 1'b0;
  assign mgmt_serial_clock_line_out.oe  = hw_ok && !smb_q && m_scl_q;
  assign mgmt_serial_data_line_out.out  = 1'b0;
  assign mgmt_serial_data_line_out.oe   = hw_ok &&
                                          (smb_q ? s_oe_q : m_sda_q);
  assign usb_attach_out            = attach_q;
  assign port_power_enable_out     = {2{attach_q}};
  assign eeprom_error_out          = ee_err_q;
  assign smbus_mode_out            = smb_q;
  assign serial_port_sleep_bit_out = sleep_q;
  assign cfg_rd_data_out           = cfg_rd_q;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_all);

  sequence q_addr_byte;
    s_fall && (s_st_q == hub_cfg_pkg::S_ADDR) && !s_rd_q &&
    (s_bit_q == 4'h7);
  endsequence
  sequence q_nacked;
    !s_oe_q && (s_st_q == hub_cfg_pkg::S_IGNORE);
  endsequence
  // Own disable: the common reset would mask the very case checked
  property p_float;
    disable iff (srst_in)
    !hw_ok |-> !mgmt_serial_data_line_out.oe &&
               !mgmt_serial_clock_line_out.oe;
  endproperty
  a_float: assert property (p_float) else $error("pins driven in reset");
  property p_no_clk;
    smb_q |-> !mgmt_serial_clock_line_out.oe && (m_st_q == hub_cfg_pkg::M_IDLE);
  endproperty
  a_no_clk: assert property (p_no_clk) else $error("clock or master used");
  property p_gcall;
    q_addr_byte and (s_sh_q[7:1] == hub_cfg_pkg::GEN_CALL) |=> q_nacked;
  endproperty
  a_gcall: assert property (p_gcall) else $error("general call acked");
  property p_badaddr;
    q_addr_byte and (s_sh_q[7:1] != slave_addr_in) |=> q_nacked;
  endproperty
  a_badaddr: assert property (p_badaddr) else $error("wrong address acked");
  property p_count;
    s_fall && (s_st_q == hub_cfg_pkg::S_CNT) && (s_bit_q == 4'h7) &&
    ((s_sh_q == 8'h00) || (s_sh_q > 8'h20)) |=> q_nacked;
  endproperty
  a_count: assert property (p_count) else $error("bad count acked");
  property p_tout;
    s_tout |=> (s_st_q == hub_cfg_pkg::S_IDLE) && !s_oe_q;
  endproperty
  a_tout: assert property (p_tout) else $error("timeout not taken");
  property p_stop;
    s_stop |=> (s_st_q == hub_cfg_pkg::S_IDLE) && !s_oe_q;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left slave busy");
  property p_protect;
    attach_q && c_busy_q |-> !reg_we;
  endproperty
  a_protect: assert property (p_protect) else $error("protected write");
  property p_commit;
    $rose(c_busy_q) |-> $past(s_stop) &&
                        ($past(s_st_q) == hub_cfg_pkg::S_WDATA);
  endproperty
  a_commit: assert property (p_commit) else $error("commit without stop");
  property p_boot;
    $rose(op_q) && !smb_q |-> ##[1:260] (m_st_q == hub_cfg_pkg::M_START);
  endproperty
  a_boot: assert property (p_boot) else $error("EEPROM load not started");
  property p_rate;
    qtick |=> !qtick [*8];
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate too fast");
  property p_attach;
    smb_q && $rose(attach_q) |-> $past(stat_wr);
  endproperty
  a_attach: assert property (p_attach) else $error("attach before load");
endmodule

// ### hub_cfg_pkg.sv
/* Constants, states and pin carrier for the hub configuration load port.
   Assumes a 100 MHz system clock and open-drain pins resolved outside. */
package hub_cfg_pkg;
  localparam int         CLK_HZ    = 100000000;
  localparam int         EE_BPS    = 100000;
  localparam int         QTR_CYC   = CLK_HZ / (EE_BPS * 4);
  localparam int         TOUT_MS   = 25;
  localparam int         TOUT_CYC  = (CLK_HZ / 1000) * TOUT_MS;
  localparam int         READY_MS  = 35;
  localparam int         OPER_US   = 500;
  localparam int         OPER_CYC  = (CLK_HZ / 1000000) * OPER_US;
  localparam logic [6:0] EE_ADDR   = 7'h50;
  localparam logic [7:0] EE_WADDR  = 8'h00;
  localparam logic [6:0] GEN_CALL  = 7'h00;
  localparam logic [7:0] STAT_REG  = 8'hFF;
  localparam int         ATT_BIT   = 0;
  localparam int         SRST_BIT  = 1;
  localparam int         SLEEP_BIT = 2;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] UNDEF_RD  = 8'h00;
  localparam logic [5:0] BLK_MAX   = 6'h20;
  localparam logic [1:0] SEL_SMBUS = 2'h1;

  typedef struct packed {
    logic out;
    logic oe;
  } od_pin_t;

  typedef enum logic [2:0] {
    M_IDLE  = 3'h0,
    M_START = 3'h1,
    M_TX    = 3'h2,
    M_RX    = 3'h3,
    M_STOP  = 3'h4,
    M_DONE  = 3'h5
  } m_state_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_ADDR   = 3'h1,
    S_CMD    = 3'h2,
    S_CNT    = 3'h3,
    S_WDATA  = 3'h4,
    S_RDATA  = 3'h5,
    S_IGNORE = 3'h6
  } s_state_t;
endpackage

// ### host_model.sv
/* Host model for the management serial bus, bit-level tasks.
   Assumes open-drain wires with pull-ups resolved by the bench. */
`timescale 1ns/1ns
module host_model (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  // Quarter-bit 31 ns gives a 125 ns bit; 1 means released
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic start();
    sda_out = 1'b1;
    #31 scl_out = 1'b1;
    #31 sda_out = 1'b0;
    #31 scl_out = 1'b0;
    #31;
  endtask
  task automatic stop();
    sda_out = 1'b0;
    #31 scl_out = 1'b1;
    #31 sda_out = 1'b1;
    #62;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_out = b;
    #31 scl_out = 1'b1;
    #31 r = sda_in;
    #31 scl_out = 1'b0;
    #32;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ### hub_config_load_port_tb.sv
/* Testbench for the configuration load port in management mode, then EEPROM load mode.
   Assumes the host model drives the far side through pull-ups. */
`timescale 1ns/1ns
module hub_config_load_port_tb;
  logic                 mclk_in = 1'b0;
  logic                 srst_in = 1'b1;
  logic                 hw_n    = 1'b1;
  logic [7:0]           rd_a    = 8'h00;
  logic [7:0]           rd_d;
  logic [7:0]           d;
  logic [1:0]           ports;
  logic                 scl_h, sda_h, ack, att, mode;
  logic                 sel_hi  = 1'b0;
  logic                 sel_lo  = 1'b1;
  logic                 err;
  logic                 slp;
  hub_cfg_pkg::od_pin_t scl_o, sda_o;
  int                   failures  = 0;
  int                   tests_run = 0;
  wire                  scl_w = scl_h & ~scl_o.oe;
  wire                  sda_w = sda_h & ~sda_o.oe;
  hub_config_load_port #(.TOUT_CYC(2000), .OPER_CYC(100), .EE_LAST(8'h03))
    hub_config_load_port_inst (.mclk_in(mclk_in), .srst_in(srst_in),
    .hw_reset_n_in(hw_n), .config_source_select_hi_in(sel_hi),
    .config_source_select_lo_in(sel_lo), .slave_addr_in(7'h2C),
    .mgmt_serial_clock_line_in(scl_w), .mgmt_serial_data_line_in(sda_w),
    .cfg_rd_addr_in(rd_a), .mgmt_serial_clock_line_out(scl_o),
    .mgmt_serial_data_line_out(sda_o), .usb_attach_out(att),
    .port_power_enable_out(ports), .eeprom_error_out(err),
    .smbus_mode_out(mode), .serial_port_sleep_bit_out(slp),
    .cfg_rd_data_out(rd_d));
  host_model host_model_inst (.sda_in(sda_w), .scl_out(scl_h),
    .sda_out(sda_h));
  initial
    forever #5 mclk_in = ~mclk_in;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_in) rd_a = a;
    repeat (3) @(negedge mclk_in);
    chk(rd_d, e);
  endtask
  // Count is sent as given so refusals can be provoked
  task automatic wr(input logic [6:0] a, input logic [7:0] c, n, d0, d1);
    host_model_inst.start();
    host_model_inst.put({a, 1'b0}, ack);
    if (ack)
      host_model_inst.put(c, ack);
    if (ack)
      host_model_inst.put(n, ack);
    if (ack)
      host_model_inst.put(d0, ack);
    if (ack)
      host_model_inst.put(d1, ack);
    host_model_inst.stop();
  endtask
  task automatic test_done();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge mclk_in);
    srst_in = 1'b0;
    repeat (110) @(negedge mclk_in);
    chk({7'h00, mode}, 8'h01);
    chk({7'h00, att}, 8'h00);
    wr(7'h2C, 8'h10, 8'h02, 8'hA5, 8'h3C);
    rreg(8'h10, 8'hA5);
    rreg(8'h11, 8'h3C);
    wr(7'h2D, 8'h10, 8'h02, 8'h00, 8'h00);
    chk({7'h00, ack}, 8'h00);
    wr(7'h00, 8'h10, 8'h02, 8'h00, 8'h00);
    chk({7'h00, ack}, 8'h00);
    wr(7'h2C, 8'h10, 8'h00, 8'h11, 8'h22);
    chk({7'h00, ack}, 8'h00);
    rreg(8'h10, 8'hA5);
    rreg(8'h80, 8'h00);
    $display("write tests done");
    host_model_inst.start();
    host_model_inst.put({7'h2C, 1'b0}, ack);
    host_model_inst.put(8'h11, ack);
    host_model_inst.start();
    host_model_inst.put({7'h2C, 1'b1}, ack);
    host_model_inst.get(1'b0, d);
    chk(d, 8'h20);
    host_model_inst.get(1'b1, d);
    chk(d, 8'h3C);
    host_model_inst.stop();
    $display("read test done");
    // Clock held low past the limit: the late data byte finds an idle slave
    host_model_inst.start();
    host_model_inst.put({7'h2C, 1'b0}, ack);
    host_model_inst.put(8'h10, ack);
    host_model_inst.put(8'h01, ack);
    repeat (2100) @(negedge mclk_in);
    host_model_inst.put(8'h77, ack);
    chk({7'h00, ack}, 8'h00);
    host_model_inst.stop();
    rreg(8'h10, 8'hA5);
    wr(7'h2C, 8'hFE, 8'h02, 8'h00, 8'h02);
    rreg(8'h10, 8'h00);
    repeat (110) @(negedge mclk_in);
    wr(7'h2C, 8'h20, 8'h02, 8'hC3, 8'h00);
    rreg(8'h20, 8'hC3);
    $display("timeout and soft reset tests done");
    wr(7'h2C, 8'hFE, 8'h02, 8'h00, 8'h01);
    repeat (4) @(negedge mclk_in);
    chk({6'h00, ports}, 8'h03);
    wr(7'h2C, 8'h10, 8'h02, 8'h55, 8'h66);
    rreg(8'h10, 8'h00);
    wr(7'h2C, 8'hFE, 8'h02, 8'h00, 8'h04);
    repeat (4) @(negedge mclk_in);
    chk({7'h00, slp}, 8'h01);
    wr(7'h2C, 8'h10, 8'h02, 8'h00, 8'h00);
    chk({7'h00, ack}, 8'h00);
    hw_n   = 1'b0;
    sel_hi = 1'b1;
    repeat (4) @(negedge mclk_in);
    chk({6'h00, scl_o.oe, sda_o.oe}, 8'h00);
    chk({4'h0, slp, att, ports}, 8'h00);
    repeat (100) @(negedge mclk_in);
    hw_n = 1'b1;
    repeat (110) @(negedge mclk_in);
    rreg(8'h20, 8'h00);
    // No EEPROM answers, so the address byte is refused and load ends
    for (int i = 0; i < 13000 && !att; i++)
      @(negedge mclk_in);
    chk({5'h00, mode, err, att}, 8'h03);
    $display("reset and EEPROM tests done");
    test_done();
  end
endmodule
